/* tfcr_regs.sv */
/*
 * Framer control register bank: identity, factory test, two receive and
 * one transmit control registers, plus the control behaviour they steer:
 * resync start, out-of-frame detection, sync qualification, error count
 * select and transmit path selection.
 * Assumes a synchronous 8-bit register port decoded upstream from the
 * parallel bus, and line-side status/data pins asynchronous to i_clk.
 */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - identity read-only, fixed variant bit
// - low nibble holds revision
// - criteria picks resync causes
// - out-of-frame 2/4, 2/5 or 2/6
// - superframe search mode
// - extended superframe check confirm
// - qualify 10 or 24 bits
// - disable bit stops auto resync
// - request rising edge starts resync
// - optional signaling bit error report
// - count bit errors or multiframe losses
// - clock failover when tx clock stops
// - framing bits internal or serial
// - check bits internal or serial
// - robbed-bit signaling enable
// - global bit-seven stuffing
// - datalink source select
// - blue alarm enable
// - remote alarm enable
// - remote alarm format select
module tfcr_regs
    import tfcr_pkg::*;
#(
    parameter logic [3:0] REVISION = ID_REVISION_DEFAULT
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // register port
    input wire logic i_cs,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire tfcr_pkg::tfcr_addr_t i_addr,
    input wire tfcr_pkg::tfcr_data_t i_wdata,
    output tfcr_pkg::tfcr_data_t o_rdata,
    // receive framer events, from line logic (asynchronous)
    input wire logic i_rx_carrier_loss,
    input wire logic i_fbit_sample,
    input wire logic i_ft_error,
    input wire logic i_fs_error,
    input wire logic i_is_ft_pos,
    input wire logic i_esf_mode,
    input wire logic i_check_ok,
    input wire logic i_multiframe_loss,
    // transmit clocks (asynchronous levels)
    input wire logic i_tx_line_clock_in,
    input wire logic i_recovered_rx_clock_out,
    // receive framer controls and status
    output logic o_resync_start,
    output logic o_out_of_frame,
    output logic o_in_sync,
    output logic o_search_cross_couple,
    output logic o_search_check_confirm,
    output logic o_framing_error_event,
    output logic o_error_count_event,
    output logic o_line_violation_count_function,
    output logic o_receive_code_select,
    output logic o_rx_zero_byte_slot_interchange_en,
    output logic o_rx_frame_pulse_double_wide,
    output logic o_rx_frame_pulse_mode,
    output logic o_rx_frame_pulse_direction,
    output logic o_rx_superframe_remote_alarm_format,
    // transmit formatter controls
    output logic o_tx_clock_sel_recovered,
    output logic [1:0] o_fbit_source,
    output logic [1:0] o_check_bits_source,
    output logic o_robbed_bit_signaling_enable,
    output logic o_global_bit_seven_stuff,
    output logic o_tx_datalink_source_select,
    output logic o_tx_blue_alarm,
    output logic o_tx_remote_alarm
);
    tfcr_data_t test_a_q, test_b_q, rx_a_q, rx_b_q, tx_a_q, rdata_q;
    logic req_prev_q, resync_q, oof_q, in_sync_q, err_ev_q, cnt_ev_q;
    logic [5:0] err_hist_q;
    logic [4:0] qual_q;
    logic [2:0] win_len, err_cnt;
    logic [3:0] ev_s;
    logic [3:0] fr_s;
    logic [1:0] clk_s;
    logic txclk_stopped, fbit_err, fire_auto, realign_req;
    tfcr_data_t id_value;

    tfcr_sync #(.WIDTH(4)) u_sync_ev (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async({i_rx_carrier_loss, i_fbit_sample, i_esf_mode, i_check_ok}),
        .o_sync(ev_s)
    );

    tfcr_sync #(.WIDTH(4)) u_sync_fr (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async({i_ft_error, i_fs_error, i_is_ft_pos, i_multiframe_loss}),
        .o_sync(fr_s)
    );

    tfcr_sync #(.WIDTH(2)) u_sync_clk (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async({i_tx_line_clock_in, i_recovered_rx_clock_out}),
        .o_sync(clk_s)
    );

    tfcr_clk_mon u_clk_mon (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_clk_level(clk_s[1]),
        .o_stopped(txclk_stopped)
    );

    // register writes
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            test_a_q <= RST_ZERO;
            test_b_q <= RST_ZERO;
            rx_a_q <= RST_ZERO;
            rx_b_q <= RST_ZERO;
            tx_a_q <= RST_ZERO;
        end else if (i_cs && i_wr) begin
            unique case (i_addr)
                OFS_FACTORY_TEST_A: test_a_q <= i_wdata;
                OFS_FACTORY_TEST_B: test_b_q <= i_wdata;
                OFS_RECEIVE_CONTROL_A: rx_a_q <= i_wdata;
                OFS_RECEIVE_CONTROL_B: rx_b_q <= i_wdata;
                OFS_TRANSMIT_CONTROL_A: tx_a_q <= i_wdata;
                default: ;
            endcase
        end
    end

    // identity is constant
    always_comb begin
        id_value = '0;
        id_value[ID_VARIANT_BIT] = ID_VARIANT_T1;
        id_value[ID_REV_LSB +: ID_REV_W] = REVISION;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q <= RD_UNMAPPED;
        end else if (i_cs && i_rd) begin
            unique case (i_addr)
                OFS_FACTORY_TEST_A: rdata_q <= test_a_q;
                OFS_FACTORY_TEST_B: rdata_q <= test_b_q;
                OFS_CHIP_IDENTITY: rdata_q <= id_value;
                OFS_RECEIVE_CONTROL_A: rdata_q <= rx_a_q;
                OFS_RECEIVE_CONTROL_B: rdata_q <= rx_b_q;
                OFS_TRANSMIT_CONTROL_A: rdata_q <= tx_a_q;
                default: rdata_q <= RD_UNMAPPED;
            endcase
        end
    end
    assign o_rdata = rdata_q;

    // signaling-bit errors only when enabled
    assign fbit_err = ev_s[2] && (fr_s[3] ||
        (rx_b_q[RB_SIGNALING_FRAME_BIT_ERROR_REPORT] && fr_s[2] && !fr_s[1]));

    // out-of-frame window length
    always_comb begin
        if (rx_a_q[RA_FRAME_LOSS_SELECT_B]) begin
            win_len = OOF_WIN_6;
        end else if (rx_a_q[RA_FRAME_LOSS_SELECT_A]) begin
            win_len = OOF_WIN_5;
        end else begin
            win_len = OOF_WIN_4;
        end
    end

    // error count over the newest win_len framing bits
    always_comb begin
        err_cnt = '0;
        for (int i = 0; i < 6; i++) begin
            if (3'(i) < win_len && err_hist_q[i]) begin
                err_cnt = err_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            err_hist_q <= '0;
        end else if (resync_q) begin
            err_hist_q <= '0;
        end else if (ev_s[2]) begin
            err_hist_q <= {err_hist_q[4:0], fbit_err};
        end
    end

    // sticky out-of-frame, cleared when a resync starts
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            oof_q <= 1'b0;
        end else if (in_sync_q && !resync_q && err_cnt >= OOF_ERRS) begin
            oof_q <= 1'b1;
        end else if (resync_q) begin
            oof_q <= 1'b0;
        end
    end

    // auto resync trigger: carrier loss counts only with criteria clear
    assign fire_auto = !rx_a_q[RA_AUTO_REALIGN_DISABLE] &&
        (oof_q || (!rx_a_q[RA_AUTO_REALIGN_CRITERIA] && ev_s[3]));
    assign realign_req = rx_a_q[RA_REALIGN_REQUEST] && !req_prev_q;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_prev_q <= 1'b0;
            resync_q <= 1'b0;
        end else begin
            req_prev_q <= rx_a_q[RA_REALIGN_REQUEST];
            // one-cycle pulse: sync only drops on the edge after it
            resync_q <= realign_req || (fire_auto && in_sync_q && !resync_q);
        end
    end
    assign o_resync_start = resync_q;
    assign o_out_of_frame = oof_q;

    // sync qualification count of clean framing bits
    // failing check restarts qualification
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            qual_q <= '0;
            in_sync_q <= 1'b0;
        end else if (resync_q) begin
            qual_q <= '0;
            in_sync_q <= 1'b0;
        end else if (!in_sync_q && ev_s[2]) begin
            if (fbit_err || (o_search_check_confirm && !ev_s[0])) begin
                qual_q <= '0;
            end else if (qual_q + 5'h01 >= (rx_a_q[RA_ALIGN_QUALIFY_TIME] ?
                    SYNC_QUAL_LONG : SYNC_QUAL_SHORT)) begin
                in_sync_q <= 1'b1;
            end else begin
                qual_q <= qual_q + 5'h01;
            end
        end
    end
    assign o_in_sync = in_sync_q;

    // search strategy per framing mode
    assign o_search_cross_couple = !ev_s[1] && rx_a_q[RA_ALIGN_SEARCH_CRITERIA];
    assign o_search_check_confirm = ev_s[1] && rx_a_q[RA_ALIGN_SEARCH_CRITERIA];

    // error counter increment source
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            err_ev_q <= 1'b0;
            cnt_ev_q <= 1'b0;
        end else begin
            err_ev_q <= fbit_err;
            cnt_ev_q <= rx_b_q[RB_MULTIFRAME_LOSS_COUNT_SELECT] ? fr_s[0] : fbit_err;
        end
    end
    assign o_framing_error_event = err_ev_q;
    assign o_error_count_event = cnt_ev_q;

    assign o_line_violation_count_function = rx_a_q[RA_LINE_VIOLATION_COUNT_FUNCTION];
    assign o_receive_code_select = rx_b_q[RB_RECEIVE_CODE_SELECT];
    assign o_rx_zero_byte_slot_interchange_en = rx_b_q[RB_RX_ZBTSI_EN];
    assign o_rx_frame_pulse_double_wide = rx_b_q[RB_RX_FRAME_PULSE_DOUBLE_WIDE];
    assign o_rx_frame_pulse_mode = rx_b_q[RB_RX_FRAME_PULSE_MODE];
    assign o_rx_frame_pulse_direction = rx_b_q[RB_RX_FRAME_PULSE_DIRECTION];
    assign o_rx_superframe_remote_alarm_format =
        rx_b_q[RB_RX_SUPERFRAME_REMOTE_ALARM_FORMAT];

    // failover only when enabled and the tx clock has stopped
    assign o_tx_clock_sel_recovered =
        tx_a_q[TA_TX_CLOCK_FAILOVER_CONTROL] && txclk_stopped;

    assign o_fbit_source = tx_a_q[TA_TX_FRAMING_BIT_PASSTHROUGH] ?
        TFCR_SRC_SERIAL_IN : TFCR_SRC_INTERNAL;
    assign o_check_bits_source = tx_a_q[TA_TX_CHECK_BITS_PASSTHROUGH] ?
        TFCR_SRC_SERIAL_IN : TFCR_SRC_INTERNAL;
    assign o_robbed_bit_signaling_enable = tx_a_q[TA_ROBBED_BIT_SIGNALING_ENABLE];
    assign o_global_bit_seven_stuff = tx_a_q[TA_GLOBAL_BIT_SEVEN_STUFF];
    assign o_tx_datalink_source_select = tx_a_q[TA_TX_DATALINK_SOURCE_SELECT];
    assign o_tx_blue_alarm = tx_a_q[TA_TX_BLUE_ALARM];
    assign o_tx_remote_alarm = tx_a_q[TA_TX_REMOTE_ALARM];
endmodule
`default_nettype wire

/* tfcr_pkg.sv */
/*
 * Framer control register constants.
 * Assumes one 100 MHz clock.
 */
package tfcr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    typedef logic [ADDR_W-1:0] tfcr_addr_t;
    typedef logic [DATA_W-1:0] tfcr_data_t;

    // register offsets
    localparam tfcr_addr_t OFS_FACTORY_TEST_A = 8'h09;
    localparam tfcr_addr_t OFS_CHIP_IDENTITY = 8'h0F;
    localparam tfcr_addr_t OFS_RECEIVE_CONTROL_A = 8'h2B;
    localparam tfcr_addr_t OFS_RECEIVE_CONTROL_B = 8'h2C;
    localparam tfcr_addr_t OFS_TRANSMIT_CONTROL_A = 8'h35;
    localparam tfcr_addr_t OFS_FACTORY_TEST_B = 8'h7D;

    localparam tfcr_data_t RST_ZERO = 8'h00;
    localparam tfcr_data_t RD_UNMAPPED = 8'h00;

    // chip_identity fields
    localparam int ID_VARIANT_BIT = 7;
    localparam int ID_REV_LSB = 0;
    localparam int ID_REV_W = 4;
    localparam logic ID_VARIANT_T1 = 1'b0;
    // arbitrary neutral revision value
    localparam logic [3:0] ID_REVISION_DEFAULT = 4'h1;

    // receive_control_a fields
    localparam int RA_LINE_VIOLATION_COUNT_FUNCTION = 7;
    localparam int RA_AUTO_REALIGN_CRITERIA = 6;
    localparam int RA_FRAME_LOSS_SELECT_A = 5;
    localparam int RA_FRAME_LOSS_SELECT_B = 4;
    localparam int RA_ALIGN_SEARCH_CRITERIA = 3;
    localparam int RA_ALIGN_QUALIFY_TIME = 2;
    localparam int RA_AUTO_REALIGN_DISABLE = 1;
    localparam int RA_REALIGN_REQUEST = 0;

    // receive_control_b fields
    localparam int RB_RECEIVE_CODE_SELECT = 7;
    localparam int RB_RX_ZBTSI_EN = 6;
    localparam int RB_RX_FRAME_PULSE_DOUBLE_WIDE = 5;
    localparam int RB_RX_FRAME_PULSE_MODE = 4;
    localparam int RB_RX_FRAME_PULSE_DIRECTION = 3;
    localparam int RB_RX_SUPERFRAME_REMOTE_ALARM_FORMAT = 2;
    localparam int RB_SIGNALING_FRAME_BIT_ERROR_REPORT = 1;
    localparam int RB_MULTIFRAME_LOSS_COUNT_SELECT = 0;

    // transmit_control_a fields
    localparam int TA_TX_CLOCK_FAILOVER_CONTROL = 7;
    localparam int TA_TX_FRAMING_BIT_PASSTHROUGH = 6;
    localparam int TA_TX_CHECK_BITS_PASSTHROUGH = 5;
    localparam int TA_ROBBED_BIT_SIGNALING_ENABLE = 4;
    localparam int TA_GLOBAL_BIT_SEVEN_STUFF = 3;
    localparam int TA_TX_DATALINK_SOURCE_SELECT = 2;
    localparam int TA_TX_BLUE_ALARM = 1;
    localparam int TA_TX_REMOTE_ALARM = 0;

    // out-of-frame thresholds: errors out of a window of framing bits
    localparam logic [2:0] OOF_ERRS = 3'h2;
    localparam logic [2:0] OOF_WIN_4 = 3'h4;
    localparam logic [2:0] OOF_WIN_5 = 3'h5;
    localparam logic [2:0] OOF_WIN_6 = 3'h6;

    // qualifying framing bits before sync is declared
    localparam logic [4:0] SYNC_QUAL_SHORT = 5'h0A;
    localparam logic [4:0] SYNC_QUAL_LONG = 5'h18;

    // transmit clock loss: no edge within this time means stopped
    localparam int TXCLK_LOSS_NS = 2000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TXCLK_LOSS_CYC = TXCLK_LOSS_NS / CLK_PERIOD_NS;
    localparam int TXCLK_CNT_W = 8;

    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        TFCR_SRC_INTERNAL,
        TFCR_SRC_SERIAL_IN
    } tfcr_src_e;
endpackage

/* tfcr_sync.sv */
/*
 * Two-flop synchroniser.
 * Assumes asynchronous inputs.
 */
`timescale 1ns/1ps
`default_nettype none
module tfcr_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // first stage feeds only the second
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule
`default_nettype wire

/* tfcr_clk_mon.sv */
/*
 * Tx clock stop monitor.
 * Assumes a synchronised level.
 */
`timescale 1ns/1ps
`default_nettype none
module tfcr_clk_mon
    import tfcr_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // monitored clock level, synchronised
    input wire logic i_clk_level,
    // status
    output logic o_stopped
);
    localparam logic [TXCLK_CNT_W-1:0] LOSS_LIMIT = TXCLK_CNT_W'(TXCLK_LOSS_CYC);

    logic prev_q;
    logic [TXCLK_CNT_W-1:0] idle_q;
    logic stopped_q;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= i_clk_level;
        end
    end

    // saturating count of cycles since the last edge
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            idle_q <= '0;
            stopped_q <= 1'b0;
        end else if (prev_q != i_clk_level) begin
            idle_q <= '0;
            stopped_q <= 1'b0;
        end else if (idle_q >= LOSS_LIMIT) begin
            stopped_q <= 1'b1;
        end else begin
            idle_q <= idle_q + 1'b1;
        end
    end

    assign o_stopped = stopped_q;
endmodule
`default_nettype wire

/* tfcr_regs_props.sv */
/*
 * Port checker for the register bank.
 * Assumes one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module tfcr_regs_props
    import tfcr_pkg::*;
#(
    parameter logic [3:0] REVISION = ID_REVISION_DEFAULT
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // register port
    input wire logic i_cs,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire tfcr_pkg::tfcr_addr_t i_addr,
    input wire tfcr_pkg::tfcr_data_t i_wdata,
    input wire tfcr_pkg::tfcr_data_t o_rdata,
    // watched controls
    input wire logic o_resync_start,
    input wire logic o_in_sync,
    input wire logic o_search_cross_couple,
    input wire logic o_search_check_confirm,
    input wire logic o_tx_clock_sel_recovered,
    input wire logic [1:0] o_fbit_source,
    input wire logic [1:0] o_check_bits_source,
    input wire logic o_robbed_bit_signaling_enable,
    input wire logic o_global_bit_seven_stuff,
    input wire logic o_tx_datalink_source_select,
    input wire logic o_tx_blue_alarm,
    input wire logic o_tx_remote_alarm
);
    wire logic rd = i_cs && i_rd;
    wire logic wr_a = i_cs && i_wr && i_addr == OFS_RECEIVE_CONTROL_A;
    wire logic wr_t = i_cs && i_wr && i_addr == OFS_TRANSMIT_CONTROL_A;
    wire logic mapped = i_addr inside {OFS_FACTORY_TEST_A, OFS_CHIP_IDENTITY,
        OFS_RECEIVE_CONTROL_A, OFS_RECEIVE_CONTROL_B, OFS_TRANSMIT_CONTROL_A, OFS_FACTORY_TEST_B};
    logic req_q;
    logic ad_q;
    logic sc_q;
    logic fo_q;
    logic [1:0] rise_q;

    // shadow of written control bits
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_q <= 1'b0;
            ad_q <= 1'b0;
            sc_q <= 1'b0;
            fo_q <= 1'b0;
            rise_q <= 2'b00;
        end else begin
            rise_q <= {rise_q[0], wr_a && i_wdata[0] && !req_q};
            if (wr_a) begin
                req_q <= i_wdata[0];
                ad_q <= i_wdata[1];
                sc_q <= i_wdata[3];
            end
            if (wr_t) begin
                fo_q <= i_wdata[7];
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    id_value_a:
        assert property (rd && i_addr == OFS_CHIP_IDENTITY |=> o_rdata == {4'h0, REVISION})
        else $error("identity read wrong");
    unmapped_zero_a:
        assert property (rd && !mapped |=> o_rdata == RD_UNMAPPED)
        else $error("unmapped read not zero");
    rdata_hold_a:
        assert property (!rd |=> $stable(o_rdata)) else $error("read data moved");
    resync_start_a:
        assert property (wr_a && i_wdata[0] && !req_q |-> ##[1:2] o_resync_start)
        else $error("no resync pulse");
    resync_single_a:
        assert property (o_resync_start |=> !o_resync_start) else $error("resync too long");
    auto_off_a:
        assert property (ad_q && $past(ad_q) && rise_q == 2'b00 |-> !o_resync_start)
        else $error("auto resync while disabled");
    resync_clears_a:
        assert property (o_resync_start |-> ##[1:2] !o_in_sync) else $error("sync kept");
    search_mode_a:
        assert property (o_search_cross_couple || o_search_check_confirm
            |-> sc_q && !(o_search_cross_couple && o_search_check_confirm))
        else $error("search mode wrong");
    failover_off_a:
        assert property (!fo_q && !$past(fo_q) && !$past(fo_q, 2) |-> !o_tx_clock_sel_recovered)
        else $error("clock switched while off");
    tx_mirror_a:
        assert property (wr_t |=> {o_fbit_source, o_check_bits_source,
            o_robbed_bit_signaling_enable, o_global_bit_seven_stuff, o_tx_datalink_source_select,
            o_tx_blue_alarm, o_tx_remote_alarm} == {1'b0, $past(i_wdata[6]), 1'b0,
            $past(i_wdata[5:0])})
        else $error("transmit controls wrong");
endmodule
bind tfcr_regs tfcr_regs_props #(.REVISION(REVISION)) props_u (.i_clk, .i_rst_n, .i_cs,
    .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata, .o_resync_start, .o_in_sync,
    .o_search_cross_couple, .o_search_check_confirm, .o_tx_clock_sel_recovered,
    .o_fbit_source, .o_check_bits_source, .o_robbed_bit_signaling_enable,
    .o_global_bit_seven_stuff, .o_tx_datalink_source_select, .o_tx_blue_alarm,
    .o_tx_remote_alarm);
`default_nettype wire

/* tfcr_host_model.sv */
/*
 * Host model for the register port.
 * Assumes requests taken on the rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module tfcr_host_model
    import tfcr_pkg::*;
(
    // clock
    input wire logic i_clk,
    // register port
    output logic o_cs,
    output logic o_wr,
    output logic o_rd,
    output tfcr_pkg::tfcr_addr_t o_addr,
    output tfcr_pkg::tfcr_data_t o_wdata,
    input wire tfcr_pkg::tfcr_data_t i_rdata
);
    initial begin
        o_cs = 1'b0;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end

    // held across the taking edge
    task automatic access(input logic w, input tfcr_addr_t a, input tfcr_data_t d,
                          output tfcr_data_t q);
        @(negedge i_clk);
        o_cs = 1'b1;
        o_wr = w;
        o_rd = !w;
        o_addr = a;
        o_wdata = d;
        @(posedge i_clk);
        @(negedge i_clk);
        q = i_rdata;
        o_cs = 1'b0;
        o_wr = 1'b0;
        o_rd = 1'b0;
        // released lines move
        o_addr = ~a;
        o_wdata = ~d;
    endtask

    task automatic init();
        tfcr_data_t q;
        access(1'b1, OFS_FACTORY_TEST_A, 8'h00, q);
        access(1'b1, OFS_FACTORY_TEST_B, 8'h00, q);
    endtask
endmodule
`default_nettype wire

/* test_tfcr_regs.sv */
/*
 * Bench for the register bank.
 * Assumes the host model and checker.
 */
`timescale 1ns/1ps
`default_nettype none
module test_tfcr_regs;
    import tfcr_pkg::*;
    localparam logic [3:0] REV = 4'h3;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic cs, wr, rd, cl = 1'b0, fb = 1'b0, fte = 1'b0, fse = 1'b0, ftp = 1'b1;
    logic txc = 1'b0, rxc = 1'b0, txc_run = 1'b1;
    tfcr_addr_t addr;
    tfcr_data_t wdata, rdata;
    logic rs, oof, ins, fee, sel;
    logic [1:0] fsrc, csrc;
    logic [5:0] rxo;
    logic [4:0] txo;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;

    tfcr_host_model host_u (.i_clk(i_clk), .o_cs(cs), .o_wr(wr), .o_rd(rd), .o_addr(addr),
        .o_wdata(wdata), .i_rdata(rdata));
    tfcr_regs #(.REVISION(REV)) dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs(cs), .i_wr(wr),
        .i_rd(rd), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .i_rx_carrier_loss(cl),
        .i_fbit_sample(fb), .i_ft_error(fte), .i_fs_error(fse), .i_is_ft_pos(ftp),
        .i_esf_mode(1'b0), .i_check_ok(1'b0), .i_multiframe_loss(1'b0),
        .i_tx_line_clock_in(txc), .i_recovered_rx_clock_out(rxc), .o_resync_start(rs),
        .o_out_of_frame(oof), .o_in_sync(ins), .o_search_cross_couple(),
        .o_search_check_confirm(), .o_framing_error_event(fee), .o_error_count_event(),
        .o_line_violation_count_function(), .o_receive_code_select(rxo[5]),
        .o_rx_zero_byte_slot_interchange_en(rxo[4]), .o_rx_frame_pulse_double_wide(rxo[3]),
        .o_rx_frame_pulse_mode(rxo[2]), .o_rx_frame_pulse_direction(rxo[1]),
        .o_rx_superframe_remote_alarm_format(rxo[0]), .o_tx_clock_sel_recovered(sel),
        .o_fbit_source(fsrc), .o_check_bits_source(csrc),
        .o_robbed_bit_signaling_enable(txo[4]), .o_global_bit_seven_stuff(txo[3]),
        .o_tx_datalink_source_select(txo[2]), .o_tx_blue_alarm(txo[1]),
        .o_tx_remote_alarm(txo[0]));

    initial forever #5 i_clk = ~i_clk;
    initial forever #41 rxc = ~rxc;
    always #323 if (txc_run) txc = ~txc;

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            $display("ERROR run length expected 20000 seen more");
            stop_test();
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input tfcr_addr_t a, input tfcr_data_t d);
        tfcr_data_t q;
        host_u.access(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input tfcr_addr_t a, input tfcr_data_t exp);
        tfcr_data_t q;
        host_u.access(1'b0, a, 8'h00, q);
        check($sformatf("register %h", a), exp, q);
    endtask

    // sel 0 resync, sel 1 error event
    task automatic pulses(input int sel, input int n, output logic [7:0] c);
        c = 8'h00;
        repeat (n) begin
            @(posedge i_clk);
            #1;
            c += (sel == 0) ? rs : fee;
        end
    endtask

    // n framing bits, each plus sync delay
    task automatic fbit(input logic ft_err, input logic fs_err, input logic at_ft, int n);
        repeat (n) begin
            @(negedge i_clk);
            {fb, fte, fse, ftp} = {1'b1, ft_err, fs_err, at_ft};
            @(negedge i_clk);
            {fb, fte, fse} = 3'b000;
            repeat (2) @(negedge i_clk);
        end
    endtask

    task automatic t_ident();
        rd_chk(OFS_CHIP_IDENTITY, {ID_VARIANT_T1, 3'b000, REV});
        wr_reg(OFS_CHIP_IDENTITY, 8'hFF);
        rd_chk(OFS_CHIP_IDENTITY, {ID_VARIANT_T1, 3'b000, REV});
        wr_reg(8'h90, 8'h5A);
        rd_chk(8'h90, RD_UNMAPPED);
        rd_chk(OFS_RECEIVE_CONTROL_A, RST_ZERO);
    endtask

    task automatic t_storage();
        tfcr_data_t pats [2] = '{8'hA5, 8'h5A};
        foreach (pats[i]) begin
            wr_reg(OFS_FACTORY_TEST_A, pats[i]);
            rd_chk(OFS_FACTORY_TEST_A, pats[i]);
            wr_reg(OFS_FACTORY_TEST_B, pats[i]);
            rd_chk(OFS_FACTORY_TEST_B, pats[i]);
            wr_reg(OFS_RECEIVE_CONTROL_B, pats[i]);
            rd_chk(OFS_RECEIVE_CONTROL_B, pats[i]);
            check("rx outputs", {2'b00, pats[i][7:2]}, {2'b00, rxo});
            wr_reg(OFS_TRANSMIT_CONTROL_A, pats[i] & 8'h7F);
            rd_chk(OFS_TRANSMIT_CONTROL_A, pats[i] & 8'h7F);
            check("tx outputs", {1'b0, pats[i][6:0]}, {1'b0, fsrc[0], csrc[0], txo});
        end
        wr_reg(OFS_RECEIVE_CONTROL_B, 8'h00);
    endtask

    task automatic t_resync();
        logic [7:0] c;
        wr_reg(OFS_RECEIVE_CONTROL_A, 8'h03);
        pulses(0, 6, c);
        check("resync on rise", 8'h01, c);
        wr_reg(OFS_RECEIVE_CONTROL_A, 8'h03);
        pulses(0, 6, c);
        check("resync held high", 8'h00, c);
        wr_reg(OFS_RECEIVE_CONTROL_A, 8'h02);
        wr_reg(OFS_RECEIVE_CONTROL_A, 8'h03);
        pulses(0, 6, c);
        check("resync re-armed", 8'h01, c);
    endtask

    task automatic t_framing();
        logic [7:0] c;
        wr_reg(OFS_RECEIVE_CONTROL_A, 8'h00);
        fbit(1'b0, 1'b0, 1'b1, 9);
        check("sync after 9", 8'h00, {7'h00, ins});
        fbit(1'b0, 1'b0, 1'b1, 1);
        check("sync after 10", 8'h01, {7'h00, ins});
        fbit(1'b1, 1'b0, 1'b1, 1);
        fbit(1'b0, 1'b0, 1'b1, 1);
        fork
            fbit(1'b1, 1'b0, 1'b1, 1);
            pulses(0, 8, c);
        join
        check("auto resync 2 of 4", 8'h01, c);
        wr_reg(OFS_RECEIVE_CONTROL_A, 8'h02);
        fbit(1'b0, 1'b0, 1'b1, 10);
        fork
            fbit(1'b0, 1'b1, 1'b0, 1);
            pulses(1, 8, c);
        join
        check("fs error hidden", 8'h00, c);
        wr_reg(OFS_RECEIVE_CONTROL_B, 8'h02);
        fork
            fbit(1'b0, 1'b1, 1'b0, 1);
            pulses(1, 8, c);
        join
        check("fs error reported", 8'h01, c);
        wr_reg(OFS_RECEIVE_CONTROL_B, 8'h00);
        fork
            fbit(1'b1, 1'b0, 1'b1, 3);
            pulses(0, 24, c);
        join
        check("no auto resync", 8'h00, c);
        check("out of frame", 8'h01, {7'h00, oof});
    endtask

    task automatic t_failover();
        wr_reg(OFS_TRANSMIT_CONTROL_A, 8'h80);
        repeat (300) @(negedge i_clk);
        check("clock running", 8'h00, {7'h00, sel});
        txc_run = 1'b0;
        repeat (300) @(negedge i_clk);
        check("clock stopped", 8'h01, {7'h00, sel});
        wr_reg(OFS_TRANSMIT_CONTROL_A, 8'h00);
        repeat (5) @(negedge i_clk);
        check("failover off", 8'h00, {7'h00, sel});
        txc_run = 1'b1;
    endtask

    initial begin
        repeat (20) @(negedge i_clk);
        i_rst_n = 1'b1;
        host_u.init();
        t_ident();
        t_storage();
        t_resync();
        t_framing();
        t_failover();
        stop_test();
    end
endmodule
`default_nettype wire
